/* File: hw/dpram_core.sv */
// two-port synchronous ram, 64K words of 18 bits, with burst counters
// assumes the host drives every port input from logic on clk_i
// Function
// RL1 - shared 64K x 18 array, either port reads or writes any address
// RL2 - address, control and write data captured on the rising clock edge
// RL3 - chip enables deselect the port: lanes float, port in standby
// RL4 - upper lane is bits 9..17, lower lane bits 0..8, own select
// RL5 - write stores only lanes whose byte select is low
// RL6 - read drives only selected lanes while output enable is low
// RL7 - both byte selects high: no read, no write, lanes float
// RL8 - output enable high floats both lanes at once, clock ignored
// RL9 - counter reset low loads zero and the access uses address zero
// RL10 - address strobe low loads external address and uses it
// RL11 - strobe and counter enable high reuse the previous address
// RL12 - counter enable low uses previous address plus one
// RL13 - address strobe loads even while the port is deselected
// RL14 - counter advances on enable even while the port is deselected
// RL15 - pipelined read data arrives one cycle after flow-through data
// RL16 - host should hold read high while strobing an address; the core still stores a write made under a strobe
// RL17 - flow/pipeline select high chooses pipelined timing
// RL18 - deselect floats the outputs after the next rising edge; pipelined timing floats them one edge later
// RL19 - all inputs synchronous except output enable and timing select
// RL20 - counter is 16 bits and wraps from top address to zero
// RL21 - same-address read during other port write is undefined
`timescale 1ns/1ps
`default_nettype none

module dpram_core (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          chip_select_n_a_i,
  input  wire logic                          chip_select_p_a_i,
  input  wire logic                          read_write_a_i,
  input  wire logic                          output_enable_n_a_i,
  input  wire logic                          upper_byte_select_n_a_i,
  input  wire logic                          lower_byte_select_n_a_i,
  input  wire logic                          address_strobe_n_a_i,
  input  wire logic                          counter_enable_n_a_i,
  input  wire logic                          counter_reset_n_a_i,
  input  wire logic                          flow_or_pipeline_select_a_i,
  input  wire logic [dpram_pkg::ADDR_W-1:0]  address_bus_a_i,
  input  wire logic [dpram_pkg::DATA_W-1:0]  data_bus_a_i,
  output logic      [dpram_pkg::DATA_W-1:0]  data_bus_a_o,
  output logic      [dpram_pkg::DATA_W-1:0]  data_bus_oe_a_o,
  output logic                               standby_a_o,
  input  wire logic                          chip_select_n_b_i,
  input  wire logic                          chip_select_p_b_i,
  input  wire logic                          read_write_b_i,
  input  wire logic                          output_enable_n_b_i,
  input  wire logic                          upper_byte_select_n_b_i,
  input  wire logic                          lower_byte_select_n_b_i,
  input  wire logic                          address_strobe_n_b_i,
  input  wire logic                          counter_enable_n_b_i,
  input  wire logic                          counter_reset_n_b_i,
  input  wire logic                          flow_or_pipeline_select_b_i,
  input  wire logic [dpram_pkg::ADDR_W-1:0]  address_bus_b_i,
  input  wire logic [dpram_pkg::DATA_W-1:0]  data_bus_b_i,
  output logic      [dpram_pkg::DATA_W-1:0]  data_bus_b_o,
  output logic      [dpram_pkg::DATA_W-1:0]  data_bus_oe_b_o,
  output logic                               standby_b_o
);

  // the array itself is not reset; contents are unknown after power-up
  logic [dpram_pkg::DATA_W-1:0] mem [dpram_pkg::DEPTH];

  dpram_pkg::state_t          st_reg;
  dpram_pkg::state_t          st_next;
  logic [dpram_pkg::ADDR_W-1:0] addr_a;
  logic [dpram_pkg::ADDR_W-1:0] addr_b;
  logic [1:0]                   wr_lanes_a;
  logic [1:0]                   wr_lanes_b;

  // counter reset beats the strobe, the strobe beats the counter enable
  function automatic dpram_pkg::addr_src_t addr_source(
    input logic rst_n, input logic ads_n, input logic counter_enable_n_n);
    if (!rst_n) begin
      return dpram_pkg::SRC_ZERO;                     // see RL9
    end else if (!ads_n) begin
      return dpram_pkg::SRC_EXT;                      // see RL10, RL13
    end else if (counter_enable_n_n) begin
      return dpram_pkg::SRC_HOLD;                     // see RL11
    end
    return dpram_pkg::SRC_INC;                        // see RL12, RL14
  endfunction

  // address used by this access; the 16-bit sum wraps to zero
  function automatic logic [dpram_pkg::ADDR_W-1:0] addr_pick(
    input dpram_pkg::addr_src_t src,
    input logic [dpram_pkg::ADDR_W-1:0] cnt,
    input logic [dpram_pkg::ADDR_W-1:0] ext);
    case (src)
      dpram_pkg::SRC_ZERO: return dpram_pkg::CNT_RESET;
      dpram_pkg::SRC_EXT:  return ext;
      dpram_pkg::SRC_HOLD: return cnt;
      dpram_pkg::SRC_INC:  return cnt + dpram_pkg::CNT_STEP; // see RL20
      default:             return cnt;
    endcase
  endfunction

  // per-lane active mask of a selected port, upper lane in bit 1
  function automatic logic [1:0] lanes_of(
    input logic cs_n, input logic cs_p, input logic ub_n, input logic lb_n);
    if (cs_n || !cs_p) begin
      return 2'h0;                                    // see RL3
    end
    return {~ub_n, ~lb_n};                            // see RL4, RL7
  endfunction

  // lane mask widened to the data bus, used for both port drivers
  function automatic logic [dpram_pkg::DATA_W-1:0] lane_expand(
    input logic [1:0] lanes);
    return {{dpram_pkg::LANE_W{lanes[dpram_pkg::LANE_UPPER]}},
            {dpram_pkg::LANE_W{lanes[dpram_pkg::LANE_LOWER]}}};
  endfunction

  // one port's next state from this edge's captured inputs
  function automatic dpram_pkg::port_state_t port_step(
    input dpram_pkg::port_state_t cur,
    input logic [dpram_pkg::ADDR_W-1:0] addr,
    input logic [1:0] lanes,
    input logic rw,
    input logic stby,
    input logic [dpram_pkg::DATA_W-1:0] word);
    dpram_pkg::port_state_t nxt;
    nxt            = cur;
    nxt.cnt        = addr;                            // see RL11
    nxt.lanes_flow = rw ? lanes : dpram_pkg::LANES_RESET; // see RL6, RL18
    nxt.lanes_pipe = cur.lanes_flow;                  // see RL15
    nxt.rd_flow    = word;
    nxt.rd_pipe    = cur.rd_flow;                     // see RL15
    nxt.standby    = stby;                            // see RL3
    return nxt;
  endfunction

  // address and write lanes of this edge for each port
  always_comb begin
    addr_a = addr_pick(addr_source(counter_reset_n_a_i, address_strobe_n_a_i,
                                   counter_enable_n_a_i),
                       st_reg.a.cnt, address_bus_a_i);
    addr_b = addr_pick(addr_source(counter_reset_n_b_i, address_strobe_n_b_i,
                                   counter_enable_n_b_i),
                       st_reg.b.cnt, address_bus_b_i);
    wr_lanes_a = read_write_a_i ? 2'h0 :
                 lanes_of(chip_select_n_a_i, chip_select_p_a_i,
                          upper_byte_select_n_a_i, lower_byte_select_n_a_i);
    wr_lanes_b = read_write_b_i ? 2'h0 :
                 lanes_of(chip_select_n_b_i, chip_select_p_b_i,
                          upper_byte_select_n_b_i, lower_byte_select_n_b_i);
  end

  // next state; the read sees the word before this edge's write lands
  always_comb begin
    st_next   = st_reg;
    st_next.a = port_step(st_reg.a, addr_a,
                  lanes_of(chip_select_n_a_i, chip_select_p_a_i,
                           upper_byte_select_n_a_i, lower_byte_select_n_a_i),
                  read_write_a_i, chip_select_n_a_i || !chip_select_p_a_i,
                  mem[addr_a]);
    st_next.b = port_step(st_reg.b, addr_b,
                  lanes_of(chip_select_n_b_i, chip_select_p_b_i,
                           upper_byte_select_n_b_i, lower_byte_select_n_b_i),
                  read_write_b_i, chip_select_n_b_i || !chip_select_p_b_i,
                  mem[addr_b]);
  end

  // all port state captured on the rising edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;                              // see RL2
    end
  end

  // lane writes; a same-address clash between ports leaves port b's word,
  // which the host must treat as undefined
  always_ff @(posedge clk_i) begin
    if (rst_n_i) begin
      if (wr_lanes_a[dpram_pkg::LANE_UPPER]) begin    // see RL5
        mem[addr_a][dpram_pkg::DATA_W-1:dpram_pkg::LANE_W] <=
          data_bus_a_i[dpram_pkg::DATA_W-1:dpram_pkg::LANE_W];
      end
      if (wr_lanes_a[dpram_pkg::LANE_LOWER]) begin
        mem[addr_a][dpram_pkg::LANE_W-1:0] <= data_bus_a_i[dpram_pkg::LANE_W-1:0];
      end
      if (wr_lanes_b[dpram_pkg::LANE_UPPER]) begin    // see RL1, RL21
        mem[addr_b][dpram_pkg::DATA_W-1:dpram_pkg::LANE_W] <=
          data_bus_b_i[dpram_pkg::DATA_W-1:dpram_pkg::LANE_W];
      end
      if (wr_lanes_b[dpram_pkg::LANE_LOWER]) begin
        mem[addr_b][dpram_pkg::LANE_W-1:0] <= data_bus_b_i[dpram_pkg::LANE_W-1:0];
      end
    end
  end

  // timing select and output enable act without the clock
  always_comb begin
    data_bus_a_o    = flow_or_pipeline_select_a_i ? st_reg.a.rd_pipe
                                                  : st_reg.a.rd_flow; // see RL17
    data_bus_b_o    = flow_or_pipeline_select_b_i ? st_reg.b.rd_pipe
                                                  : st_reg.b.rd_flow;
    data_bus_oe_a_o = output_enable_n_a_i ? '0 :              // see RL8, RL19
      lane_expand(flow_or_pipeline_select_a_i ? st_reg.a.lanes_pipe
                                              : st_reg.a.lanes_flow);
    data_bus_oe_b_o = output_enable_n_b_i ? '0 :
      lane_expand(flow_or_pipeline_select_b_i ? st_reg.b.lanes_pipe
                                              : st_reg.b.lanes_flow);
    standby_a_o     = st_reg.a.standby;
    standby_b_o     = st_reg.b.standby;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_cnt_zero;
    !counter_reset_n_a_i |=> st_reg.a.cnt == dpram_pkg::CNT_RESET;
  endproperty
  a_cnt_zero: assert property (p_cnt_zero) // see RL9
    else $error("counter reset did not give address zero");

  property p_cnt_load;
    counter_reset_n_a_i && !address_strobe_n_a_i && chip_select_n_a_i
      |=> st_reg.a.cnt == $past(address_bus_a_i);
  endproperty
  a_cnt_load: assert property (p_cnt_load) // see RL10, RL13
    else $error("strobe did not load the external address");

  property p_cnt_hold;
    counter_reset_n_a_i && address_strobe_n_a_i && counter_enable_n_a_i
      |=> $stable(st_reg.a.cnt);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) // see RL11
    else $error("counter moved while disabled");

  property p_cnt_inc;
    counter_reset_n_a_i && address_strobe_n_a_i && !counter_enable_n_a_i
      |=> st_reg.a.cnt == 16'($past(st_reg.a.cnt) + dpram_pkg::CNT_STEP);
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) // see RL12, RL14, RL20
    else $error("counter did not advance by one");

  property p_oe_float;
    output_enable_n_a_i |-> data_bus_oe_a_o == '0;
  endproperty
  a_oe_float: assert property (p_oe_float) // see RL8
    else $error("port drives with output enable high");

  property p_deselect;
    chip_select_n_a_i && !flow_or_pipeline_select_a_i
      ##1 !flow_or_pipeline_select_a_i |-> data_bus_oe_a_o == '0 && standby_a_o;
  endproperty
  a_deselect: assert property (p_deselect) // see RL3, RL18
    else $error("deselected port still drives");

  property p_upper_mask;
    !chip_select_n_a_i && chip_select_p_a_i && read_write_a_i
      && upper_byte_select_n_a_i && !lower_byte_select_n_a_i
      && !output_enable_n_a_i && !flow_or_pipeline_select_a_i
      ##1 !output_enable_n_a_i && !flow_or_pipeline_select_a_i
      |-> data_bus_oe_a_o == {{9{1'b0}}, {9{1'b1}}};
  endproperty
  a_upper_mask: assert property (p_upper_mask) // see RL4, RL6, RL7
    else $error("lane enables wrong on lower-lane read");

  sequence s_wr_then_rd;
    !chip_select_n_a_i && chip_select_p_a_i && !read_write_a_i
      && !upper_byte_select_n_a_i && !lower_byte_select_n_a_i
      && counter_reset_n_a_i && !address_strobe_n_a_i
    ##1 !chip_select_n_a_i && chip_select_p_a_i && read_write_a_i
      && counter_reset_n_a_i && !address_strobe_n_a_i
      && address_bus_a_i == $past(address_bus_a_i);
  endsequence

  property p_flow_read;
    s_wr_then_rd ##0 !flow_or_pipeline_select_a_i
      |=> !flow_or_pipeline_select_a_i ->
          data_bus_a_o == $past(data_bus_a_i, 2);
  endproperty
  a_flow_read: assert property (p_flow_read) // see RL1, RL5
    else $error("flow-through read lost the written word");

  property p_pipe_read;
    s_wr_then_rd ##0 flow_or_pipeline_select_a_i
      ##1 flow_or_pipeline_select_a_i
      |=> flow_or_pipeline_select_a_i ->
          data_bus_a_o == $past(data_bus_a_i, 3);
  endproperty
  a_pipe_read: assert property (p_pipe_read) // see RL15, RL17
    else $error("pipelined read not one cycle late");

  property p_cross_read;
    !chip_select_n_a_i && chip_select_p_a_i && !read_write_a_i
      && !upper_byte_select_n_a_i && !lower_byte_select_n_a_i
      && counter_reset_n_a_i && !address_strobe_n_a_i
    ##1 counter_reset_n_b_i && !address_strobe_n_b_i
      && address_bus_b_i == $past(address_bus_a_i)
      && !flow_or_pipeline_select_b_i && wr_lanes_a == 2'h0
      |=> !flow_or_pipeline_select_b_i ->
          data_bus_b_o == $past(data_bus_a_i, 2);
  endproperty
  a_cross_read: assert property (p_cross_read) // see RL1
    else $error("other port did not see the written word");

  c_flow_read: cover property (s_wr_then_rd ##0 !flow_or_pipeline_select_a_i);
  c_pipe_read: cover property (s_wr_then_rd ##0 flow_or_pipeline_select_a_i);
  c_burst:     cover property (!counter_enable_n_a_i [*4]);
  c_zero:      cover property (!counter_reset_n_b_i);

endmodule

`default_nettype wire

/* File: common/dpram_pkg.sv */
// shared constants and types for the two-port synchronous ram
// assumes both ports run on one system clock and a synchronous reset
package dpram_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 18;
  localparam int unsigned LANE_W = 9;
  localparam int unsigned DEPTH  = 65536;

  // lane index inside the two-bit lane masks
  localparam int unsigned LANE_UPPER = 1;
  localparam int unsigned LANE_LOWER = 0;

  // reset values of the per-port state, and the counter step
  localparam logic [ADDR_W-1:0] CNT_RESET   = 16'h0000;
  localparam logic [ADDR_W-1:0] CNT_STEP    = 16'h0001;
  localparam logic [DATA_W-1:0] DATA_RESET  = 18'h00000;
  localparam logic [1:0]        LANES_RESET = 2'h0;

  // where the address of an access comes from, gray along reset/load/hold/inc
  typedef enum logic [1:0] {
    SRC_ZERO = 2'h0,
    SRC_EXT  = 2'h1,
    SRC_HOLD = 2'h3,
    SRC_INC  = 2'h2
  } addr_src_t;

  typedef struct packed {
    logic [ADDR_W-1:0] cnt;         // address used by the last access
    logic [1:0]        lanes_flow;  // lanes driving in flow-through timing
    logic [1:0]        lanes_pipe;  // same, one cycle later
    logic [DATA_W-1:0] rd_flow;
    logic [DATA_W-1:0] rd_pipe;
    logic              standby;
  } port_state_t;

  typedef struct packed {
    port_state_t a;
    port_state_t b;
  } state_t;

endpackage

/* File: sim/dpram_host.sv */
// host model for port b: clears the burst counter, then writes eight words
// assumes it shares clk_i with the ram and is started by a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none

module dpram_host (
  input  wire logic        clk_i,
  input  wire logic        start_i,
  output logic             cs_n_o,
  output logic             cs_p_o,
  output logic             rw_o,
  output logic             ub_n_o,
  output logic             lb_n_o,
  output logic             ads_n_o,
  output logic             cen_n_o,
  output logic             crst_n_o,
  output logic             oe_n_o,
  output logic             fp_o,
  output logic [15:0]      ad_o,
  output logic [17:0]      d_o
);
  int k = -1;
  logic act;

  // step 0 clears the counter, steps 1..8 write addresses 1..8
  always @(posedge clk_i) begin
    if (start_i) begin
      k <= 0;
    end else if (k >= 0 && k < 9) begin
      k <= k + 1;
    end else begin
      k <= -1;
    end
  end

  // pins follow the step just after each edge, like a registered host
  always_comb begin
    act = k >= 0 && k <= 8;
    cs_n_o = !act;
    cs_p_o = act;
    rw_o = !(k >= 1 && k <= 8);
    ads_n_o = 1'b1; // never strobes, so no write can ride a load
    cen_n_o = !(k >= 1 && k <= 8);
    crst_n_o = k != 0;
    {ub_n_o, lb_n_o, oe_n_o} = 3'h0;
    fp_o = k[0];
    ad_o = ~k[15:0];
    // idle data is inverted so a stale value never looks valid
    d_o = act ? 18'h2A5A0 ^ k[17:0] : ~(18'h2A5A0 ^ k[17:0]);
  end
endmodule

`default_nettype wire

/* File: sim/sync_dual_port_ram_port_tb_top.sv */
// self-checking bench: port a from random stimulus, port b from host model
// assumes dpram_core and dpram_host; reference model checks every cycle
`timescale 1ns/1ps
`default_nettype none

module sync_dual_port_ram_port_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic armed = 1'b0;
  logic cs_n = 1'b1, cs_p = 1'b0, rw = 1'b1, oe_n = 1'b1, fp = 1'b0;
  logic ub_n = 1'b1, lb_n = 1'b1, ads_n = 1'b1, cen_n = 1'b1, crst_n = 1'b1;
  logic [15:0] ad = 16'h0000;
  logic [17:0] di = 18'h00000;
  wire b_cs_n, b_cs_p, b_rw, b_ub_n, b_lb_n, b_ads_n, b_cen_n, b_crst_n;
  wire b_oe_n, b_fp;
  wire [15:0] b_ad;
  wire [17:0] b_di;
  wire [1:0][17:0] dq, oe;
  wire [1:0] sbv;
  wire [1:0][7:0] ctl = {{b_cs_n, b_cs_p, b_rw, b_ub_n, b_lb_n, b_ads_n,
                          b_cen_n, b_crst_n},
                         {cs_n, cs_p, rw, ub_n, lb_n, ads_n, cen_n, crst_n}};
  wire [1:0][15:0] adv = {b_ad, ad};
  wire [1:0][17:0] dv = {b_di, di};
  wire [1:0] fpv = {b_fp, fp};
  wire [1:0] oev = {b_oe_n, oe_n};
  logic [17:0] mem [65536];
  logic [15:0] cnt [2];
  logic [1:0] lf [2], lp [2], l;
  logic [17:0] df [2], dp [2], eo, ed;
  logic sb [2];
  int mismatches = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  dpram_core i_dut (
    .clk_i(clk), .rst_n_i(rst_n),
    .chip_select_n_a_i(cs_n), .chip_select_p_a_i(cs_p),
    .read_write_a_i(rw), .output_enable_n_a_i(oe_n),
    .upper_byte_select_n_a_i(ub_n), .lower_byte_select_n_a_i(lb_n),
    .address_strobe_n_a_i(ads_n), .counter_enable_n_a_i(cen_n),
    .counter_reset_n_a_i(crst_n), .flow_or_pipeline_select_a_i(fp),
    .address_bus_a_i(ad), .data_bus_a_i(di), .data_bus_a_o(dq[0]),
    .data_bus_oe_a_o(oe[0]), .standby_a_o(sbv[0]),
    .chip_select_n_b_i(b_cs_n), .chip_select_p_b_i(b_cs_p),
    .read_write_b_i(b_rw), .output_enable_n_b_i(b_oe_n),
    .upper_byte_select_n_b_i(b_ub_n), .lower_byte_select_n_b_i(b_lb_n),
    .address_strobe_n_b_i(b_ads_n), .counter_enable_n_b_i(b_cen_n),
    .counter_reset_n_b_i(b_crst_n), .flow_or_pipeline_select_b_i(b_fp),
    .address_bus_b_i(b_ad), .data_bus_b_i(b_di), .data_bus_b_o(dq[1]),
    .data_bus_oe_b_o(oe[1]), .standby_b_o(sbv[1]));

  dpram_host i_host (
    .clk_i(clk), .start_i(start), .cs_n_o(b_cs_n), .cs_p_o(b_cs_p),
    .rw_o(b_rw), .ub_n_o(b_ub_n), .lb_n_o(b_lb_n), .ads_n_o(b_ads_n),
    .cen_n_o(b_cen_n), .crst_n_o(b_crst_n), .oe_n_o(b_oe_n), .fp_o(b_fp),
    .ad_o(b_ad), .d_o(b_di));

  // reference port: all reads of an edge happen before its writes
  task automatic step(input int p, input logic [7:0] c, input logic [15:0] a,
                      input logic [17:0] d, input bit wr);
    logic [15:0] u;
    logic sel;
    logic [17:0] w;
    u = !c[0] ? 16'h0000 : !c[2] ? a : c[1] ? cnt[p] : cnt[p] + 16'h0001;
    sel = !c[7] && c[6];
    if (wr) begin
      if (sel && !c[5]) begin
        w = mem[cnt[p]];
        if (!c[4]) w[17:9] = d[17:9];
        if (!c[3]) w[8:0] = d[8:0];
        mem[cnt[p]] = w; // port b last, so b wins a shared write
      end
    end else begin
      dp[p] = df[p];
      lp[p] = lf[p];
      df[p] = mem[u];
      lf[p] = (sel && c[5]) ? {!c[4], !c[3]} : 2'h0;
      sb[p] = !sel;
      cnt[p] = u;
    end
  endtask

  always @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      if (!rst_n) begin
        {cnt[p % 2], lf[p % 2], lp[p % 2], sb[p % 2]} = '0;
        {df[p % 2], dp[p % 2]} = '0;
      end else begin
        step(p % 2, ctl[p % 2], adv[p % 2], dv[p % 2], p > 1);
      end
    end
  end

  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // outputs settle well before the falling edge; async selects used live
  always @(negedge clk) begin
    for (int p = 0; p < 2 && armed; p++) begin
      l = fpv[p] ? lp[p] : lf[p];
      eo = oev[p] ? 18'h00000 : {{9{l[1]}}, {9{l[0]}}};
      ed = fpv[p] ? dp[p] : df[p];
      cmp(oe[p], eo);
      cmp(dq[p] & eo, ed & eo);
      cmp({17'h00000, sbv[p]}, {17'h00000, sb[p]});
    end
  end

  task automatic drive(input logic [9:0] c, input logic [15:0] a,
                       input logic [17:0] d);
    @(posedge clk);
    {cs_n, cs_p, rw, ub_n, lb_n, ads_n, cen_n, crst_n, oe_n, fp} <= c;
    ad <= a;
    di <= d;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    logic address_strobe_n;
    r = $urandom(75667);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    armed <= 1'b1;
    // fill every word by burst from a cleared counter, ending on a wrap
    for (int i = 0; i < 65537; i++)
      drive({7'b0100010, i != 0, 2'($urandom)}, 16'($urandom),
            18'($urandom));
    $display("test fill done");
    // random traffic on a while the host bursts on b
    for (int i = 0; i < 3000; i++) begin
      r = $urandom;
      address_strobe_n = r[2] | r[3];
      drive({r[9:7] == 3'h0, r[6:4] != 3'h0, r[10] | ~address_strobe_n, r[12:11], address_strobe_n,
             r[13], r[17:14] != 4'h0, r[19:18]}, 16'($urandom),
            18'($urandom)); // read held high while strobing
      start <= i == 100;
    end
    $display("test random done");
    // write under a strobe, then read the same word back in each timing
    // mode; away from the host's words so port b cannot collide
    for (int f = 0; f < 2; f++) begin
      drive({8'b01000011, 1'b0, f[0]}, 16'h4C3A, 18'($urandom));
      repeat (3)
        drive({8'b01100011, 1'b0, f[0]}, 16'h4C3A, 18'h00000);
    end
    $display("test strobe write done");
    // burst read of the host's words, timing select toggling each word
    for (int i = 0; i < 9; i++)
      drive({5'b01100, i != 0, i == 0, 2'b10, i[0]}, 16'h0001,
            18'($urandom));
    repeat (3) drive(10'h200, 16'h0000, 18'h3FFFF);
    $display("test readback done");
    conclude();
  end

  // runaway guard, well past the expected length of the run
  initial begin
    repeat (75000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule

`default_nettype wire
